// file: hdl/vcp_pixel_config.v
/*
  Pixel configuration of a colour video controller: control and PLL boot
  registers on APB, pixel depth decode, palette lookup per channel, the
  composite blank pin control and the clock source select.
  Assumes one clock pclk; pixel data arrives synchronous to pclk; the
  blank pin input is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps
`include "vcp_regs.vh"
module vcp_pixel_config #(
  parameter PAL_AW = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pixel stream
  input wire pixel_valid,
  input wire [23:0] pixel_data,
  output reg rgb_valid,
  output reg [7:0] red_out,
  output reg [7:0] green_out,
  output reg [7:0] blue_out,
  // Composite blank pin and blank source
  input wire composite_blank_pin_i,
  output reg composite_blank_pin_o,
  output reg composite_blank_pin_oe,
  input wire blank_local,
  output reg blank_active,
  // Clock control
  output reg pll_enable,
  output reg [4:0] pll_multiplier,
  output reg dot_clock_direct,
  output reg video_timing_generator_en
);
  reg [23:0] display_control;
  reg [23:0] pll_boot_setting;
  reg [PAL_AW-1:0] pal_addr;
  reg cb_sync1;
  reg cb_sync2;
  reg vld_d1;
  reg vld_d2;
  reg [1:0] bpp;
  reg [PAL_AW-1:0] idx_r;
  reg [PAL_AW-1:0] idx_g;
  reg [PAL_AW-1:0] idx_b;
  reg [PAL_AW-1:0] next_idx;
  wire [23:0] pal_r;
  wire [23:0] pal_g;
  wire [23:0] pal_b;
  wire wr_acc;
  wire rd_acc;
  wire mapped;
  wire pal_we;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign mapped = (paddr == `VCP_ADDR_CTRL) | (paddr == `VCP_ADDR_BOOT) | (paddr == `VCP_ADDR_PAL) |
    (paddr == `VCP_ADDR_PALDATA) | (paddr == `VCP_ADDR_STAT);
  assign pal_we = wr_acc & (paddr == `VCP_ADDR_PALDATA);

  // Register writes; reset clears the timing generator enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_control <= `VCP_CTRL_RESET;
      pll_boot_setting <= `VCP_BOOT_RESET;
      pal_addr <= {PAL_AW{1'b0}};
    end else if (wr_acc) begin
      if (paddr == `VCP_ADDR_CTRL) begin
        display_control <= pwdata[23:0];
      end
      if (paddr == `VCP_ADDR_BOOT) begin
        pll_boot_setting <= pwdata[23:0];
      end
      if (paddr == `VCP_ADDR_PAL) begin
        pal_addr <= pwdata[PAL_AW-1:0];
      end
      if (paddr == `VCP_ADDR_PALDATA) begin
        pal_addr <= pal_addr + {{(PAL_AW-1){1'b0}}, 1'b1}; // Auto increment
      end
    end
  end

  // APB answer: zero wait states, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `VCP_ADDR_CTRL: prdata <= {8'h00, display_control};
          `VCP_ADDR_BOOT: prdata <= {8'h00, pll_boot_setting};
          `VCP_ADDR_PAL: prdata <= {{(32-PAL_AW){1'b0}}, pal_addr};
          `VCP_ADDR_STAT: prdata <= {27'h0000000, cb_sync2, blank_active, dot_clock_direct, pll_enable,
            video_timing_generator_en};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Blank pin input synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_sync1 <= 1'b0;
      cb_sync2 <= 1'b0;
    end else begin
      cb_sync1 <= composite_blank_pin_i;
      cb_sync2 <= cb_sync1;
    end
  end

  // Depth decode and index forming, one index shared by all channels
  always @* begin
    bpp = display_control[`VCP_CTRL_BPP_HI:`VCP_CTRL_BPP_LO];
    next_idx = {PAL_AW{1'b0}};
    case (bpp)
      `VCP_BPP_8: next_idx = pixel_data[PAL_AW-1:0];
      `VCP_BPP_4: next_idx[3:0] = pixel_data[3:0];
      `VCP_BPP_2: next_idx[1:0] = pixel_data[1:0];
      `VCP_BPP_1: next_idx[0] = pixel_data[0];
      default: next_idx = {PAL_AW{1'b0}};
    endcase
  end

  // Stage one: capture indices; 24-bit mode uses each field as an address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= {PAL_AW{1'b0}};
      idx_g <= {PAL_AW{1'b0}};
      idx_b <= {PAL_AW{1'b0}};
      vld_d1 <= 1'b0;
      vld_d2 <= 1'b0;
    end else begin
      vld_d1 <= pixel_valid;
      vld_d2 <= vld_d1; // Tracks the palette read stage so valid meets its data
      if (display_control[`VCP_CTRL_MODE24_BIT]) begin
        idx_r <= pixel_data[7:0];
        idx_g <= pixel_data[15:8];
        idx_b <= pixel_data[23:16];
      end else begin
        idx_r <= next_idx;
        idx_g <= next_idx;
        idx_b <= next_idx;
      end
    end
  end

  vcp_palette #(
    .AW(PAL_AW),
    .DW(24)
  ) u_palette (
    .pclk(pclk),
    .we(pal_we),
    .waddr(pal_addr),
    .wdata(pwdata[23:0]),
    .raddr_r(idx_r),
    .raddr_g(idx_g),
    .raddr_b(idx_b),
    .rdata_r(pal_r),
    .rdata_g(pal_g),
    .rdata_b(pal_b)
  );

  // Stage two: each lookup yields its own channel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_valid <= 1'b0;
      red_out <= 8'h00;
      green_out <= 8'h00;
      blue_out <= 8'h00;
    end else begin
      rgb_valid <= vld_d2;
      red_out <= pal_r[7:0];
      green_out <= pal_g[15:8];
      blue_out <= pal_b[23:16];
    end
  end

  // Blank pin direction and function; bit 23 only acts on an input pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      composite_blank_pin_oe <= 1'b0;
      composite_blank_pin_o <= 1'b0;
      blank_active <= 1'b0;
    end else begin
      composite_blank_pin_oe <= display_control[`VCP_CTRL_CBDIR_BIT];
      composite_blank_pin_o <= blank_local;
      if (display_control[`VCP_CTRL_CBDIR_BIT]) begin
        blank_active <= blank_local;
      end else begin
        blank_active <= blank_local | (cb_sync2 ^ display_control[`VCP_CTRL_CBFUNC_BIT]);
      end
    end
  end

  // Clock source from the single clock input: PLL or direct dot clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_enable <= 1'b0;
      pll_multiplier <= 5'h00;
      dot_clock_direct <= 1'b1;
      video_timing_generator_en <= 1'b0;
    end else begin
      pll_enable <= pll_boot_setting[`VCP_BOOT_PLL_BIT];
      pll_multiplier <= pll_boot_setting[`VCP_BOOT_MULT_HI:0];
      dot_clock_direct <= ~pll_boot_setting[`VCP_BOOT_PLL_BIT];
      video_timing_generator_en <= display_control[`VCP_CTRL_VTG_BIT];
    end
  end
endmodule // vcp_pixel_config

// file: hdl/vcp_regs.vh
/*
  Register offsets, field positions, reset values and encodings of the
  pixel configuration block. Assumes inclusion by bare name.
*/
`ifndef VCP_REGS_VH
`define VCP_REGS_VH

`define VCP_ADDR_CTRL 12'h000
`define VCP_ADDR_BOOT 12'h004
`define VCP_ADDR_PAL 12'h008
`define VCP_ADDR_PALDATA 12'h00c
`define VCP_ADDR_STAT 12'h010

`define VCP_CTRL_VTG_BIT 0
`define VCP_CTRL_CBDIR_BIT 16
`define VCP_CTRL_BPP_LO 17
`define VCP_CTRL_BPP_HI 18
`define VCP_CTRL_CBFUNC_BIT 23
`define VCP_CTRL_MODE24_BIT 1

`define VCP_BOOT_PLL_BIT 5
`define VCP_BOOT_MULT_HI 4

`define VCP_CTRL_RESET 24'h000000
`define VCP_BOOT_RESET 24'h000000

`define VCP_BPP_8 2'h3
`define VCP_BPP_4 2'h2
`define VCP_BPP_2 2'h1
`define VCP_BPP_1 2'h0

`endif

// file: hdl/vcp_palette.v
/*
  Palette memory: one write port, three registered read ports (red, green
  and blue lookups). Assumes a single clock and writes from the bus side.
*/
`timescale 1ns/100ps
module vcp_palette #(
  parameter AW = 8,
  parameter DW = 24
) (
  // Clock
  input wire pclk,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // Read ports
  input wire [AW-1:0] raddr_r,
  input wire [AW-1:0] raddr_g,
  input wire [AW-1:0] raddr_b,
  output reg [DW-1:0] rdata_r,
  output reg [DW-1:0] rdata_g,
  output reg [DW-1:0] rdata_b
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered reads
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr_r];
    rdata_g <= mem[raddr_g];
    rdata_b <= mem[raddr_b];
  end
endmodule // vcp_palette

// file: bench/vcp_host.sv
/* Host model: APB master and bring-up sequence.
   Assumes calls start just after a rising edge. */
`timescale 1ns/100ps
module vcp_host (
  // Bus
  input wire pclk,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  output logic psel = 0,
  output logic penable = 0,
  output logic pwrite = 0,
  output logic [11:0] paddr = 0,
  output logic [31:0] pwdata = 0
);
  logic [31:0] rv;
  logic re;
  // Setup, access until pready, release, one idle edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Boot word first, blank pin driven as output, identity palette
  task init(input logic [5:0] bw);
    integer n;
    xfer(1, 12'h004, {26'h0, bw});
    xfer(1, 12'h000, 32'h10000);
    xfer(1, 12'h008, 0);
    for (n = 0; n < 256; n++) xfer(1, 12'h00c, {8'h00, 8'(n), 8'(n), 8'(n)});
  endtask
endmodule // vcp_host

// file: bench/vcp_chk_asserts.sv
/* Checker: bus answer, register driven outputs, pixel latency.
   Assumes a bind to the top module. */
`timescale 1ns/100ps
module vcp_chk (
  // Clock, reset, bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Outputs watched
  input wire pixel_valid,
  input wire rgb_valid,
  input wire composite_blank_pin_oe,
  input wire pll_enable,
  input wire [4:0] pll_multiplier,
  input wire dot_clock_direct,
  input wire video_timing_generator_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes
  wire wc = psel & penable & pready & pwrite & (paddr == 12'h000);
  wire wb = psel & penable & pready & pwrite & (paddr == 12'h004);
  property p_oe; wc |=> ##1 composite_blank_pin_oe == $past(pwdata[16], 2); endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_vtg; wc |=> ##1 video_timing_generator_en == $past(pwdata[0], 2); endproperty
  a_vtg: assert property (p_vtg) else $error("vtg");
  property p_pll; wb |=> ##1 pll_enable == $past(pwdata[5], 2); endproperty
  a_pll: assert property (p_pll) else $error("pll");
  property p_mul; wb |=> ##1 pll_multiplier == $past(pwdata[4:0], 2); endproperty
  a_mul: assert property (p_mul) else $error("mult");
  property p_dir; dot_clock_direct != pll_enable; endproperty
  a_dir: assert property (p_dir) else $error("direct");
  property p_rst; $rose(presetn) |-> !video_timing_generator_en && dot_clock_direct; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_rgb; pixel_valid |-> ##3 rgb_valid; endproperty
  a_rgb: assert property (p_rgb) else $error("rgb");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("rdy");
  c_pix: cover property (rgb_valid);
  c_boot: cover property (wb ##2 pll_enable);
  c_in: cover property (!composite_blank_pin_oe);
endmodule // vcp_chk

// file: bench/vcp_pixel_config_tb.sv
/* Testbench: host model on APB, pixel and blank stimulus.
   Assumes host model and checker compiled first. */
`timescale 1ns/100ps
module vcp_pixel_config_tb;
  logic pclk = 0, presetn = 0, pixel_valid = 0, blank_local = 0, ext_pin = 0;
  logic [23:0] pixel_data = 0;
  logic psel, penable, pwrite, pready, pslverr, rgb_valid, pin_o, oe, blank_active, pll_enable, direct, video_timing_generator;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] r, g, b;
  logic [4:0] mult;
  integer err_count = 0, n_tests = 0, d;
  // Blank wire level from both drivers
  wire pin = oe ? pin_o : ext_pin;
  initial forever #25 pclk = ~pclk;
  vcp_host vcp_host_i (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  vcp_pixel_config vcp_pixel_config_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pixel_valid, .pixel_data, .rgb_valid, .red_out(r), .green_out(g), .blue_out(b),
    .composite_blank_pin_i(pin), .composite_blank_pin_o(pin_o), .composite_blank_pin_oe(oe), .blank_local,
    .blank_active, .pll_enable, .pll_multiplier(mult), .dot_clock_direct(direct), .video_timing_generator_en(video_timing_generator));
  task chk(input string s, input logic [32:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask
  // Write, then let outputs settle one edge
  task wr(input logic [11:0] a, input logic [31:0] v);
    vcp_host_i.xfer(1, a, v);
    @(posedge pclk);
  endtask
  task pix(input logic [23:0] v);
    pixel_valid <= 1;
    pixel_data <= v;
    @(posedge pclk);
    pixel_valid <= 0;
    repeat (8) if (rgb_valid !== 1'b1) @(posedge pclk);
    chk("valid", rgb_valid, 1);
  endtask
  task bl(input logic [31:0] v, input logic [1:0] e);
    wr(0, v);
    repeat (4) @(posedge pclk);
    chk("blank", {oe, blank_active}, e);
  endtask
  task conclude;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    vcp_host_i.init(6'h25);
    @(posedge pclk);
    chk("clk", {direct, pll_enable, mult, video_timing_generator}, 8'h4a);
    wr(12'h004, 5);
    chk("clk", {direct, pll_enable, mult}, 7'h45);
    vcp_host_i.xfer(1, 12'h020, 32'hffff);
    chk("unmapw", vcp_host_i.re, 1);
    vcp_host_i.xfer(0, 12'h000, 0);
    chk("ctrl", {vcp_host_i.re, vcp_host_i.rv}, 33'h10000);
    vcp_host_i.xfer(0, 12'h020, 0);
    chk("unmap", {vcp_host_i.re, vcp_host_i.rv}, 33'h100000000);
    $display("registers done");
    for (d = 0; d < 4; d++) begin
      wr(0, 32'h10000 | (d << 17));
      pix(24'hff);
      chk("depth", r, (1 << (1 << d)) - 1);
    end
    wr(0, 32'h70002);
    pix(24'h302010);
    chk("rgb", {b, g, r}, 24'h302010);
    // One altered entry shows that each channel really goes through the palette
    vcp_host_i.xfer(1, 12'h008, 32'h10);
    vcp_host_i.xfer(1, 12'h00c, 32'hc3b2a1);
    vcp_host_i.xfer(0, 12'h008, 0);
    chk("ptr", vcp_host_i.rv, 32'h11);
    pix(24'h101010);
    chk("lut", {b, g, r}, 24'hc3b2a1);
    pix(24'h302010);
    chk("mix", {b, g, r}, 24'h3020a1);
    $display("pixels done");
    ext_pin <= 1;
    bl(0, 1);
    bl(32'h800000, 0);
    bl(32'h810000, 2);
    bl(32'h10000, 2);
    blank_local <= 1;
    repeat (2) @(posedge pclk);
    chk("drive", {pin_o, blank_active}, 3);
    $display("blank done");
    wr(12'h004, 32'h25);
    wr(0, 32'h10001);
    chk("vtg", video_timing_generator, 1);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("rst", {video_timing_generator, direct, pll_enable}, 3'b010);
    // Boot word is written again after every reset
    wr(12'h004, 32'h25);
    chk("reboot", {direct, pll_enable}, 1);
    vcp_host_i.xfer(0, 12'h010, 0);
    chk("stat", vcp_host_i.rv, 32'h1a);
    $display("reset done");
    conclude;
  end
  // Watchdog
  initial begin
    #200000;
    err_count++;
    conclude;
  end
endmodule // vcp_pixel_config_tb
bind vcp_pixel_config vcp_chk vcp_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pixel_valid, .rgb_valid, .composite_blank_pin_oe, .pll_enable, .pll_multiplier, .dot_clock_direct,
  .video_timing_generator_en);
